// file: design/ffi_fault_flags.sv
// Two clear-on-read fault flag registers with masked interrupt output.
// Assumes comparator levels arrive asynchronously, and that the serial
// slave gives a one-cycle rd_strobe with rd_addr on ref_clk.
// Notes on behaviour
// (RULE1) Two read-only flag registers at 0xB, 0xC
// (RULE2) Only enabled flags reach the interrupt; first-register flags here have no mask and always do
// (RULE3) Read clears flag unless condition persists
// (RULE4) Bit5 sets on limit plus undervoltage
// (RULE5) Bit4 sets on bus current limit
// (RULE6) Limit flags never set when trip disabled
// (RULE7) Bit2 sets on bus undervoltage
// (RULE8) Bit1 sets on bus ground short
// (RULE9) Bit0 thermal shutdown, bit3 bus overvoltage
// (RULE10) Second register bit3 on thermal warning
// (RULE11) Second register bit2 on input overvoltage
// (RULE12) Second register bit1 on data overvoltage
// (RULE13) Mask bits 3..1 gate, reset zero
// (RULE14) Unused bits read zero, flags reset zero
// (RULE15) Interrupt follows any enabled set flag
`timescale 1ns/1ps
module ffi_fault_flags
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_current_limit_flag,
  input wire logic bus_overvoltage_flag,
  input wire logic bus_undervoltage_flag,
  input wire logic bus_ground_short_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic thermal_warning_flag,
  input wire logic input_overvoltage_flag,
  input wire logic dataline_overvoltage_flag,
  input wire logic current_trip_enable,
  input wire logic thermal_warning_enable,
  input wire logic input_overvoltage_enable,
  input wire logic dataline_overvoltage_enable,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic irq_n
);
  localparam int NCOND = 11;
  logic [NCOND-1:0] sync1_reg;
  logic [NCOND-1:0] sync2_reg;
  logic [7:0] bus_cond;
  logic [7:0] ovw_cond;
  logic [7:0] bus_flags_reg;
  logic [7:0] ovw_flags_reg;
  logic [7:0] mask_reg;
  logic [7:0] bus_flags_next;
  logic [7:0] ovw_flags_next;
  logic rd_bus;
  logic rd_ovw;
  logic irq_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Two-stage synchronisers for comparator and strap levels
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {current_trip_enable, bus_current_limit_flag,
        bus_overvoltage_flag, bus_undervoltage_flag,
        bus_ground_short_flag, thermal_shutdown_flag,
        thermal_warning_flag, input_overvoltage_flag,
        dataline_overvoltage_flag, thermal_warning_enable,
        input_overvoltage_enable};
      sync2_reg <= sync1_reg;
    end
  end

  // Live condition vectors, placed at flag bit positions
  always_comb
  begin
    bus_cond = 8'h00;
    ovw_cond = 8'h00;
    bus_cond[ffi_pkg::BIT_BUS_LIM] = sync2_reg[10] & sync2_reg[9]; // RULE5 RULE6
    bus_cond[ffi_pkg::BIT_BUS_LIM_UV] = sync2_reg[10] & sync2_reg[9]
      & sync2_reg[7]; // RULE4 RULE6
    bus_cond[ffi_pkg::BIT_BUS_OV] = sync2_reg[8]; // RULE9
    bus_cond[ffi_pkg::BIT_BUS_UV] = sync2_reg[7]; // RULE7
    bus_cond[ffi_pkg::BIT_BUS_SHORT] = sync2_reg[6]; // RULE8
    bus_cond[ffi_pkg::BIT_THERMAL_SHUTDOWN_FLAG] = sync2_reg[5]; // RULE9
    ovw_cond[ffi_pkg::BIT_THERMAL_WARNING_FLAG] = sync2_reg[4]; // RULE10
    ovw_cond[ffi_pkg::BIT_INPUT_OVERVOLTAGE_FLAG] = sync2_reg[3]; // RULE11
    ovw_cond[ffi_pkg::BIT_DATALINE_OVERVOLTAGE_FLAG] = sync2_reg[2]; // RULE12
  end

  // Data-line enable has its own synchroniser pair
  logic dov_en1_reg;
  logic dov_en2_reg;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dov_en1_reg <= 1'b0;
      dov_en2_reg <= 1'b0;
    end
    else
    begin
      dov_en1_reg <= dataline_overvoltage_enable;
      dov_en2_reg <= dov_en1_reg;
    end
  end

  // Enables collected at their mask positions
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_reg <= ffi_pkg::MASK_RESET; // RULE13
    else
    begin
      mask_reg <= 8'h00;
      mask_reg[ffi_pkg::BIT_THERMAL_WARNING_FLAG] <= sync2_reg[1]; // RULE13
      mask_reg[ffi_pkg::BIT_INPUT_OVERVOLTAGE_FLAG] <= sync2_reg[0]; // RULE13
      mask_reg[ffi_pkg::BIT_DATALINE_OVERVOLTAGE_FLAG] <= dov_en2_reg; // RULE13
    end
  end

  assign rd_bus = rd_strobe && hit(rd_addr, ffi_pkg::FLT_BUS_OFFSET);
  assign rd_ovw = rd_strobe && hit(rd_addr, ffi_pkg::FLT_OVW_OFFSET);

  // Read clears, but a live condition sets again in the same cycle
  always_comb
  begin
    bus_flags_next = (rd_bus ? 8'h00 : bus_flags_reg) | bus_cond; // RULE3
    ovw_flags_next = (rd_ovw ? 8'h00 : ovw_flags_reg) | ovw_cond; // RULE3
    bus_flags_next = bus_flags_next & ffi_pkg::FLT_BUS_USED; // RULE14
    ovw_flags_next = ovw_flags_next & ffi_pkg::FLT_OVW_USED; // RULE14
  end

  // Flag registers, set regardless of mask
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_flags_reg <= ffi_pkg::FLT_RESET; // RULE14
      ovw_flags_reg <= ffi_pkg::FLT_RESET;
    end
    else
    begin
      bus_flags_reg <= bus_flags_next; // RULE1 RULE2
      ovw_flags_reg <= ovw_flags_next; // RULE1
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else if (rd_bus)
      rd_data <= bus_flags_reg; // RULE1
    else if (rd_ovw)
      rd_data <= ovw_flags_reg; // RULE1
    else if (rd_strobe)
      rd_data <= 8'h00;
  end

  // First register has no mask bits here, so its flags always count
  assign irq_next = (|bus_flags_next) | (|(ovw_flags_next & mask_reg));
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_n <= 1'b1;
    else
      irq_n <= ~irq_next; // RULE2 RULE15
  end

  // Interrupt level mirrors the present flag registers and the mask of the cycle before,
  // since irq_n registers the next flags with the current mask_reg; a mask change
  // therefore shows one cycle late on the pin
  a_irq_follows: assert property ( // RULE15
    @(posedge ref_clk) disable iff (!rst_n)
    !irq_n == ((|bus_flags_reg) || (|(ovw_flags_reg & $past(mask_reg)))))
    else $error("irq not following flags");
  a_masked_quiet: assert property ( // RULE2
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_flags_reg == 8'h00 && (ovw_flags_reg & mask_reg) == 8'h00
     && !irq_next) |=> irq_n)
    else $error("irq without enabled flag");

  // Read clearing: a live condition must win over the clear
  a_persist_read: assert property ( // RULE3
    @(posedge ref_clk) disable iff (!rst_n)
    (rd_ovw && ovw_cond[ffi_pkg::BIT_INPUT_OVERVOLTAGE_FLAG])
    |=> ovw_flags_reg[ffi_pkg::BIT_INPUT_OVERVOLTAGE_FLAG])
    else $error("persisting flag cleared");
  a_read_clears: assert property ( // RULE3
    @(posedge ref_clk) disable iff (!rst_n)
    (rd_bus && bus_cond == 8'h00) |=> bus_flags_reg == 8'h00)
    else $error("read did not clear");

  // Flag setting and the bits that must stay quiet
  a_trip_off: assert property ( // RULE6
    @(posedge ref_clk) disable iff (!rst_n)
    !sync2_reg[10] |-> bus_cond[5:4] == 2'b00)
    else $error("limit flag with trip off");
  a_unused_zero: assert property ( // RULE14
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_flags_reg[7:6] == 2'b00) && (ovw_flags_reg[0] == 1'b0)
    && (ovw_flags_reg[7:4] == 4'h0))
    else $error("unused bit set");
  a_uv_sets: assert property ( // RULE7
    @(posedge ref_clk) disable iff (!rst_n)
    sync2_reg[7] |=> bus_flags_reg[ffi_pkg::BIT_BUS_UV])
    else $error("undervoltage flag missed");
  a_short_sets: assert property ( // RULE8
    @(posedge ref_clk) disable iff (!rst_n)
    sync2_reg[6] |=> bus_flags_reg[ffi_pkg::BIT_BUS_SHORT])
    else $error("short flag missed");
  a_warn_sets: assert property ( // RULE10
    @(posedge ref_clk) disable iff (!rst_n)
    sync2_reg[4] |=> ovw_flags_reg[ffi_pkg::BIT_THERMAL_WARNING_FLAG])
    else $error("warning flag missed");

  // Main scenarios worth seeing at least once
  c_irq_rise: cover property (@(posedge ref_clk) $fell(irq_n));
  c_read_clear: cover property (@(posedge ref_clk)
    rd_bus && bus_flags_reg != 8'h00 ##1 bus_flags_reg == 8'h00);
  c_masked_flag: cover property (@(posedge ref_clk)
    ovw_flags_reg != 8'h00 && (ovw_flags_reg & mask_reg) == 8'h00);
  c_persist_hold: cover property (@(posedge ref_clk)
    rd_ovw && ovw_cond != 8'h00 ##1 ovw_flags_reg != 8'h00);
endmodule // ffi_fault_flags

// file: design/ffi_pkg.sv
// Package for the fault flag register block: offsets, bit positions,
// reset values. Assumes an 8-bit register read port from the serial slave.
package ffi_pkg;
  localparam logic [7:0] FLT_BUS_OFFSET = 8'h0b;
  localparam logic [7:0] FLT_OVW_OFFSET = 8'h0c;
  // Bit positions, first flag register
  localparam int BIT_THERMAL_SHUTDOWN_FLAG = 0;
  localparam int BIT_BUS_SHORT = 1;
  localparam int BIT_BUS_UV = 2;
  localparam int BIT_BUS_OV = 3;
  localparam int BIT_BUS_LIM = 4;
  localparam int BIT_BUS_LIM_UV = 5;
  // Bit positions, second flag register and mask
  localparam int BIT_DATALINE_OVERVOLTAGE_FLAG = 1;
  localparam int BIT_INPUT_OVERVOLTAGE_FLAG = 2;
  localparam int BIT_THERMAL_WARNING_FLAG = 3;
  // Defined-bit masks; everything else reads zero
  localparam logic [7:0] FLT_BUS_USED = 8'h3f;
  localparam logic [7:0] FLT_OVW_USED = 8'h0e;
  localparam logic [7:0] FLT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
endpackage

// file: sim/ffi_host_model.sv
// Host model: issues register reads on the block's serial read port.
// Assumes the block samples rd_strobe and rd_addr on rising ref_clk.
`timescale 1ns/1ps
module ffi_host_model
(
  input wire logic ref_clk,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic [7:0] rd_addr
);
  // Idle port at time zero
  initial
  begin
    rd_strobe = 1'b0;
    rd_addr = 8'h00;
  end
  // One-cycle strobe, then the address flips so a stale decode shows
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    rd_strobe = 1'b1;
    rd_addr = a;
    @(negedge ref_clk);
    rd_strobe = 1'b0;
    rd_addr = ~a;
    @(negedge ref_clk);
    d = rd_data; // Sampled late; read data stands until the next strobe
  endtask
endmodule // ffi_host_model

// file: sim/test_fault_flag_irq_registers.sv
// Testbench: random fault conditions against a flag model, checked by reads.
// Assumes the flag block and the host model are compiled beforehand.
`timescale 1ns/1ps
module test_fault_flag_irq_registers;
  logic ref_clk, rst_n, trip, rd_strobe, irq_n;
  logic [7:0] c, rd_addr, rd_data, d;
  logic [2:0] en;
  // Expected read values queue up in read order
  logic [7:0] exp_q[$];
  logic [7:0] e;
  int n_errors = 0, compares = 0, seed = 32'h63ec, cyc = 0, f1 = 0, f2 = 0;
  ffi_fault_flags ffi_fault_flags_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .thermal_shutdown_flag(c[0]), .bus_ground_short_flag(c[1]),
    .bus_undervoltage_flag(c[2]), .bus_overvoltage_flag(c[3]),
    .bus_current_limit_flag(c[4]), .thermal_warning_flag(c[5]),
    .input_overvoltage_flag(c[6]), .dataline_overvoltage_flag(c[7]),
    .current_trip_enable(trip), .thermal_warning_enable(en[2]),
    .input_overvoltage_enable(en[1]), .dataline_overvoltage_enable(en[0]),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
    .irq_n(irq_n));
  ffi_host_model ffi_host_model_inst (.ref_clk(ref_clk), .rd_data(rd_data),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr));
  // Free-running 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the roughly 1050 cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  // Expected first-register flags; limit flags gated by the trip enable
  function automatic int bits1(logic [7:0] v, logic t);
    return {v[4] & v[2] & t, v[4] & t, v[3], v[2], v[1], v[0]};
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence: sparse random faults, then read both flag registers
  initial
  begin
    c = 8'h00;
    trip = 1'b0;
    en = 3'h0;
    rst_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("irq_n reset", {7'h00, irq_n}, 8'h01);
    ffi_host_model_inst.read(8'h0b, d);
    chk("reset 0b", d, 8'h00);
    ffi_host_model_inst.read(8'h0c, d);
    chk("reset 0c", d, 8'h00);
    for (int i = 0; i < 80; i++)
    begin
      @(negedge ref_clk);
      c = 8'($random(seed) & $random(seed));
      trip = 1'($random(seed));
      en = 3'($random(seed));
      // Conditions pass a two-flop synchroniser before the flags see them
      repeat (5) @(negedge ref_clk);
      f1 = f1 | bits1(c, trip);
      f2 = f2 | {c[5], c[6], c[7], 1'b0};
      chk("irq_n", {7'h00, irq_n},
        {7'h00, !(f1 != 0 || (f2 & {en, 1'b0}) != 0)});
      exp_q.push_back(f1[7:0]);
      exp_q.push_back(f2[7:0]);
      ffi_host_model_inst.read(8'h0b, d);
      e = exp_q.pop_front();
      chk("flags 0b", d, e);
      f1 = bits1(c, trip);
      ffi_host_model_inst.read(8'h0c, d);
      e = exp_q.pop_front();
      chk("flags 0c", d, e);
      f2 = {c[5], c[6], c[7], 1'b0};
      if (i % 4 == 0)
      begin
        ffi_host_model_inst.read(8'h0a, d);
        chk("unmapped", d, 8'h00);
      end
    end
    // Persisting flags survive the reads above; clear all and re-read
    @(negedge ref_clk);
    c = 8'h00;
    repeat (5) @(negedge ref_clk);
    ffi_host_model_inst.read(8'h0b, d);
    chk("persist 0b", d, f1[7:0]);
    ffi_host_model_inst.read(8'h0b, d);
    chk("cleared 0b", d, 8'h00);
    ffi_host_model_inst.read(8'h0c, d);
    chk("persist 0c", d, f2[7:0]);
    ffi_host_model_inst.read(8'h0c, d);
    chk("cleared 0c", d, 8'h00);
    // With every flag gone the interrupt must have let go
    chk("irq_n idle", {7'h00, irq_n}, 8'h01);
    wrap_up();
  end
endmodule // test_fault_flag_irq_registers
